//--- design/ldr_pkg.sv
// constants, offsets and types shared by both ends of the led driver serial link
// What this block does
// - device shifts serial_in on shift clock rise
// - frames travel most significant bit first
// - frame is 96 or 192 bits by mode
// - mode low grayscale, mode high trim
// - strobe high copies shift register transparently
// - strobe low holds grayscale and trim registers
// - host shifts whole frame before strobing
// - shifting allowed during running pwm cycle
// - host strobes grayscale right after the frame, not at cycle end
// - latched grayscale takes effect immediately
// - serial_out presents bit shifted out
// - serial_out also carries status data
// - error output open drain, low on flags
// - outputs off masks open led at error output, not open_led_flag
// - overtemp flag follows temperature comparator
// - overtemp flag included in status data
// - open led bits sampled while strobe high, loaded into status on strobe fall
// - host keeps clock and data still during strobe
// - host changes mode only with strobe low
// - outputs off forces channels off, counter reset
package ldr_pkg;
   localparam int CHANNELS     = 16;
   localparam int GS_W         = 12;
   localparam int TRIM_W       = 6;
   localparam int GS_BITS      = CHANNELS * GS_W;
   localparam int TRIM_BITS    = CHANNELS * TRIM_W;
   localparam int STATUS_W     = CHANNELS + 1;
   localparam int CNT_W        = 8;
   // ------------------------------------------------------------
   // link timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCLK_HALF_NS  = 80;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ------------------------------------------------------------
   // host register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TX0    = 8'h10;
   localparam logic [7:0] OFS_RX0    = 8'h30;
   localparam int         WORDS      = GS_BITS / 32;
   localparam int CTRL_START   = 0;
   localparam int CTRL_MODE    = 1;
   localparam int CTRL_OFF     = 2;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_ERR     = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
   typedef enum logic {MODE_GRAY, MODE_TRIM} ldr_mode_t;
endpackage : ldr_pkg

//--- design/ldr_link_if.sv
// serial link between the led driver and its host controller
`timescale 1ns/1ps
`default_nettype none
interface ldr_link_if;
   logic sclk;
   logic serial_in;
   logic serial_out;
   logic latch_strobe;
   logic mode;
   logic outputs_off;
   logic err_oe;
   logic error_out_n;
   // open drain with pull-up: low only while the device pulls
   assign error_out_n = ~err_oe;
   modport dev (
      input  sclk,
      input  serial_in,
      input  latch_strobe,
      input  mode,
      input  outputs_off,
      output serial_out,
      output err_oe
   );
   modport host (
      output sclk,
      output serial_in,
      output latch_strobe,
      output mode,
      output outputs_off,
      input  serial_out,
      input  error_out_n
   );
endinterface : ldr_link_if
`default_nettype wire

//--- design/ldr_sync.sv
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module ldr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : ldr_sync
`default_nettype wire

//--- design/ldr_device.sv
// led driver end: serial load, latches, status readback, error output, pwm
`timescale 1ns/1ps
`default_nettype none
module ldr_device #(
   parameter int CH = ldr_pkg::CHANNELS
) (
   input  wire logic                             core_clk,
   input  wire logic                             rstn,
   ldr_link_if.dev                               link,
   input  wire logic                             gsclk,
   input  wire logic                             overtemp_cmp,
   input  wire logic [CH-1:0]                    open_led_det,
   output var  logic [ldr_pkg::GS_BITS-1:0]      grayscale_value,
   output var  logic [ldr_pkg::TRIM_BITS-1:0]    current_trim_value,
   output var  logic [CH-1:0]                    channel_output,
   output var  logic                             overtemp_flag,
   output var  logic                             open_led_flag
);
   import ldr_pkg::*;

   if (CH != CHANNELS) begin : g_bad_ch
      $error("ldr_device: channel count fixed by frame layout");
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic            sclk_s;
   logic            sin_s;
   logic            latch_s;
   logic            mode_s;
   logic            off_s;
   logic            gsclk_s;
   logic            temp_s;
   logic [CH-1:0]   lod_s;

   ldr_sync #(.W(5)) u_link_sync (
      .clk  (core_clk),
      .rstn (rstn),
      .d    ({link.sclk, link.serial_in, link.latch_strobe, link.mode, link.outputs_off}),
      .q    ({sclk_s, sin_s, latch_s, mode_s, off_s})
   );

   ldr_sync #(.W(CH + 2)) u_side_sync (
      .clk  (core_clk),
      .rstn (rstn),
      .d    ({gsclk, overtemp_cmp, open_led_det}),
      .q    ({gsclk_s, temp_s, lod_s})
   );

   // ------------------------------------------------------------
   // edge detection on synchronised levels
   // ------------------------------------------------------------
   logic sclk_d_r;
   logic latch_d_r;
   logic gsclk_d_r;
   logic sclk_rise;
   logic latch_fall;
   logic gsclk_rise;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_d_r  <= 1'b0;
         latch_d_r <= 1'b0;
         gsclk_d_r <= 1'b0;
      end else begin
         sclk_d_r  <= sclk_s;
         latch_d_r <= latch_s;
         gsclk_d_r <= gsclk_s;
      end
   end

   assign sclk_rise  = sclk_s & ~sclk_d_r;
   assign latch_fall = ~latch_s & latch_d_r;
   assign gsclk_rise = gsclk_s & ~gsclk_d_r;

   // ------------------------------------------------------------
   // input shift register
   // ------------------------------------------------------------
   logic [GS_BITS-1:0]  shift_r;
   logic [STATUS_W-1:0] status;
   logic [CH-1:0]       open_led_flag_cap_r;

   assign status = {open_led_flag_cap_r, overtemp_flag};

   // strobe high means the host keeps sclk still, so no shift can race the copy
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         shift_r <= '0;
      end else if (sclk_rise && !latch_s) begin
         shift_r <= {shift_r[GS_BITS-2:0], sin_s};
      end else if (latch_fall) begin
         // status lands at the head of the active frame so it leaves first
         if (mode_s == MODE_TRIM) begin
            shift_r[TRIM_BITS-1 -: STATUS_W] <= status;
         end else begin
            shift_r[GS_BITS-1 -: STATUS_W] <= status;
         end
      end
   end

   // open led bits are sampled each cycle while the strobe is high
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         open_led_flag_cap_r <= '0;
      end else if (latch_s) begin
         open_led_flag_cap_r <= lod_s;
      end
   end

   // serial_out taps the last stage of the active length
   logic serial_out_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         serial_out_r <= 1'b0;
      end else begin
         serial_out_r <= (mode_s == MODE_TRIM) ? shift_r[TRIM_BITS-1] : shift_r[GS_BITS-1];
      end
   end
   assign link.serial_out = serial_out_r;

   // ------------------------------------------------------------
   // grayscale and trim latches
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         grayscale_value <= '0;
      end else if (latch_s && mode_s == MODE_GRAY) begin
         grayscale_value <= shift_r;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         current_trim_value <= '0;
      end else if (latch_s && mode_s == MODE_TRIM) begin
         current_trim_value <= shift_r[TRIM_BITS-1:0];
      end
   end

   // ------------------------------------------------------------
   // error flags and open-drain output
   // ------------------------------------------------------------
   logic err_oe_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         overtemp_flag <= 1'b0;
         open_led_flag <= 1'b0;
         err_oe_r      <= 1'b0;
      end else begin
         overtemp_flag <= temp_s;
         open_led_flag <= |lod_s;
         err_oe_r      <= temp_s | ((|lod_s) & ~off_s);
      end
   end
   assign link.err_oe = err_oe_r;

   // ------------------------------------------------------------
   // grayscale pwm
   // ------------------------------------------------------------
   logic [GS_W-1:0] gs_cnt_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gs_cnt_r <= '0;
      end else if (off_s) begin
         gs_cnt_r <= '0;
      end else if (gsclk_rise) begin
         gs_cnt_r <= gs_cnt_r + 1'b1;
      end
   end

   // new values act mid-cycle: there is no second buffer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         channel_output <= '0;
      end else begin
         for (int i = 0; i < CH; i++) begin
            channel_output[i] <= ~off_s & (gs_cnt_r < grayscale_value[i*GS_W +: GS_W]);
         end
      end
   end
endmodule : ldr_device
`default_nettype wire

//--- design/ldr_host.sv
// host end: wishbone registers driving the serial load sequence
`timescale 1ns/1ps
`default_nettype none
module ldr_host #(
   parameter int HALF = ldr_pkg::SCLK_HALF_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   ldr_link_if.host         link
);
   import ldr_pkg::*;

   if (HALF < 4 || HALF > 255) begin : g_bad_half
      $error("ldr_host: HALF out of range");
   end

   typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_LAT_HI, ST_LAT_LO} ldr_state_t;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction : merge

   logic [31:0]        tx_mem [WORDS];
   logic [31:0]        ctrl_r;
   logic [GS_BITS-1:0] rx_r;
   logic [GS_BITS-1:0] frame_r;
   logic [CNT_W-1:0]   bit_r;
   logic [7:0]         div_r;
   ldr_state_t         state_r;
   logic               serial_out_s;
   logic               err_n_s;
   logic               busy;
   logic               wr;
   logic               start;

   ldr_sync #(.W(2)) u_sync (
      .clk  (core_clk),
      .rstn (rstn),
      .d    ({link.serial_out, link.error_out_n}),
      .q    ({serial_out_s, err_n_s})
   );

   assign busy  = (state_r != ST_IDLE);
   assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign start = wr && wb_adr_i == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START] && !busy;

   // ------------------------------------------------------------
   // wishbone slave: one wait state, unmapped reads give zero
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= '0;
         if (wb_adr_i == OFS_CTRL) begin
            wb_dat_o <= ctrl_r;
         end else if (wb_adr_i == OFS_STATUS) begin
            wb_dat_o <= {30'h0000_0000, ~err_n_s, busy};
         end else begin
            for (int i = 0; i < WORDS; i++) begin
               if (wb_adr_i == OFS_TX0 + 8'(4 * i)) wb_dat_o <= tx_mem[i];
               if (wb_adr_i == OFS_RX0 + 8'(4 * i)) wb_dat_o <= rx_r[(WORDS-1-i)*32 +: 32];
            end
         end
      end
   end

   // mode and outputs-off only move while idle, so the strobe is low then
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr && wb_adr_i == OFS_CTRL && !busy) begin
         ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_0006;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < WORDS; i++) tx_mem[i] <= '0;
      end else if (wr) begin
         for (int i = 0; i < WORDS; i++) begin
            if (wb_adr_i == OFS_TX0 + 8'(4 * i)) tx_mem[i] <= merge(tx_mem[i], wb_dat_i, wb_sel_i);
         end
      end
   end

   // ------------------------------------------------------------
   // load sequencer, sclk divided from core_clk
   // ------------------------------------------------------------
   logic sclk_r;
   logic sin_r;
   logic latch_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         div_r   <= '0;
         bit_r   <= '0;
         frame_r <= '0;
         rx_r    <= '0;
         sclk_r  <= 1'b0;
         sin_r   <= 1'b0;
         latch_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  frame_r <= {tx_mem[0], tx_mem[1], tx_mem[2], tx_mem[3], tx_mem[4], tx_mem[5]};
                  bit_r   <= ctrl_r[CTRL_MODE] ? CNT_W'(TRIM_BITS - 1) : CNT_W'(GS_BITS - 1);
                  sin_r   <= ctrl_r[CTRL_MODE] ? tx_mem[3][31] : tx_mem[0][31];
                  div_r   <= '0;
                  state_r <= ST_LOW;
               end
            end
            ST_LOW: begin
               div_r <= div_r + 1'b1;
               if (div_r == 8'(HALF - 1)) begin
                  rx_r    <= {rx_r[GS_BITS-2:0], serial_out_s};
                  sclk_r  <= 1'b1;
                  div_r   <= '0;
                  state_r <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               div_r <= div_r + 1'b1;
               if (div_r == 8'(HALF - 1)) begin
                  sclk_r <= 1'b0;
                  div_r  <= '0;
                  if (bit_r == '0) begin
                     latch_r <= 1'b1;
                     state_r <= ST_LAT_HI;
                  end else begin
                     bit_r   <= bit_r - 1'b1;
                     sin_r   <= frame_r[bit_r - 1'b1];
                     state_r <= ST_LOW;
                  end
               end
            end
            ST_LAT_HI: begin
               div_r <= div_r + 1'b1;
               if (div_r == 8'(HALF - 1)) begin
                  latch_r <= 1'b0;
                  div_r   <= '0;
                  state_r <= ST_LAT_LO;
               end
            end
            ST_LAT_LO: begin
               div_r <= div_r + 1'b1;
               if (div_r == 8'(HALF - 1)) begin
                  div_r   <= '0;
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // mode and outputs-off come straight from control flops
   assign link.sclk         = sclk_r;
   assign link.serial_in    = sin_r;
   assign link.latch_strobe = latch_r;
   assign link.mode         = ctrl_r[CTRL_MODE];
   assign link.outputs_off  = ctrl_r[CTRL_OFF];
endmodule : ldr_host
`default_nettype wire

//--- verif/ldr_link_asserts.sv
// assertions on the serial link between host and led driver
`timescale 1ns/1ps
`default_nettype none
module ldr_link_asserts #(
   parameter int HALF = 4
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic latch_strobe,
   input wire logic mode,
   input wire logic err_oe,
   input wire logic error_out_n
);
   logic [8:0] rise_cnt_r;
   logic [7:0] hi_cnt_r;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ------
   // frame bookkeeping
   // ------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) rise_cnt_r <= 9'h000;
      else if (latch_strobe) rise_cnt_r <= 9'h000;
      else if ($rose(sclk)) rise_cnt_r <= rise_cnt_r + 9'h001;
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) hi_cnt_r <= 8'h00;
      else if (latch_strobe) hi_cnt_r <= hi_cnt_r + 8'h01;
      else hi_cnt_r <= 8'h00;
   end
   // ------
   // properties
   // ------
   AST_FRAME_LEN: assert property ($rose(latch_strobe) |-> rise_cnt_r == (mode ? 9'd96 : 9'd192))
      else $error("shift clock count per frame wrong");
   AST_LATCH_WIDTH: assert property ($fell(latch_strobe) |-> hi_cnt_r == 8'(HALF))
      else $error("latch pulse width wrong");
   AST_LATCH_SCLK_LOW: assert property ($rose(latch_strobe) |-> $fell(sclk))
      else $error("latch raised away from the last clock fall");
   AST_HOLD_IN_LATCH: assert property (latch_strobe && $past(latch_strobe)
         |-> $stable(sclk) && $stable(serial_in))
      else $error("link moved while latch high");
   AST_MODE_CHANGE: assert property ($changed(mode) |-> !latch_strobe && !$past(latch_strobe))
      else $error("mode changed with latch high");
   AST_SIN_ON_FALL: assert property ($changed(serial_in) |-> !sclk)
      else $error("serial input changed with clock high");
   // resync delay lets the output move only a few edges after a rise, a strobe fall or a mode change
   AST_SERIAL_OUT_AFTER_RISE: assert property ($changed(serial_out) |-> $past(sclk, 3) || $past(sclk, 4)
         || $past(sclk, 5) || $past(latch_strobe, 4) || $past(latch_strobe, 5)
         || $past(latch_strobe, 6) || ($past(mode, 3) != $past(mode, 4)))
      else $error("serial output changed without a shift");
   AST_ERR_OPEN_DRAIN: assert property (err_oe |-> ##1 (!error_out_n || !err_oe))
      else $error("error pin not low while pulled");
endmodule : ldr_link_asserts
`default_nettype wire

//--- verif/led_driver_serial_load_error_flags_test.sv
// self-checking bench for the host and led driver pair
`timescale 1ns/1ps
`default_nettype none
module led_driver_serial_load_error_flags_test;
   import ldr_pkg::*;
   logic                 core_clk = 1'b0;
   logic                 rstn = 1'b0;
   logic                 cyc = 1'b0;
   logic                 stb = 1'b0;
   logic                 we = 1'b0;
   logic [3:0]           sel = 4'h0;
   logic [7:0]           adr = 8'h00;
   logic [31:0]          wdat = 32'h0000_0000;
   logic [31:0]          rdat;
   logic                 ack;
   logic                 gsclk = 1'b0;
   logic                 ot_cmp = 1'b0;
   logic [CHANNELS-1:0]  det = 16'h0000;
   logic [GS_BITS-1:0]   gs_val;
   logic [TRIM_BITS-1:0] trim_val;
   logic [CHANNELS-1:0]  ch_out;
   logic                 ot_flag;
   logic                 lod_flag;
   logic [GS_BITS-1:0]   gs1;
   logic [TRIM_BITS-1:0] tr1;
   int                   error_cnt = 0;
   int                   tests_run = 0;
   ldr_link_if link ();
   always #2.5 core_clk = ~core_clk;
   // ------
   // instances
   // ------
   ldr_host #(.HALF(4)) i_ldr_host (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
   ldr_device i_ldr_device (.core_clk(core_clk), .rstn(rstn), .link(link), .gsclk(gsclk),
      .overtemp_cmp(ot_cmp), .open_led_det(det), .grayscale_value(gs_val),
      .current_trim_value(trim_val), .channel_output(ch_out), .overtemp_flag(ot_flag),
      .open_led_flag(lod_flag));
   ldr_link_asserts #(.HALF(4)) i_ldr_link_asserts (.core_clk(core_clk), .rstn(rstn),
      .sclk(link.sclk), .serial_in(link.serial_in), .serial_out(link.serial_out),
      .latch_strobe(link.latch_strobe), .mode(link.mode), .err_oe(link.err_oe),
      .error_out_n(link.error_out_n));
   // ------
   // helpers
   // ------
   task automatic chk(input string what, input logic [191:0] seen, input logic [191:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      wdat <= d;
      do @(posedge core_clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic load(input logic [191:0] f, input int first);
      logic [31:0] q;
      for (int k = first; k < WORDS; k++) wb(1'b1, OFS_TX0 + 8'(4 * k), f[191 - 32 * k -: 32], q);
   endtask : load
   // mode is written first so the start write sees it already stored
   task automatic run_frame(input logic [31:0] ctrl);
      logic [31:0] s;
      wb(1'b1, OFS_CTRL, ctrl, s);
      wb(1'b1, OFS_CTRL, ctrl | 32'h0000_0001, s);
      s = 32'h0000_0001;
      while (s[STAT_BUSY] !== 1'b0) wb(1'b0, OFS_STATUS, 32'h0000_0000, s);
   endtask : run_frame
   task automatic settle(input logic [31:0] ctrl);
      logic [31:0] q;
      wb(1'b1, OFS_CTRL, ctrl, q);
      repeat (8) @(posedge core_clk);
   endtask : settle
   // ------
   // scenarios
   // ------
   task automatic t_reset;
      logic [31:0] q;
      wb(1'b0, OFS_CTRL, 32'h0000_0000, q);
      chk("ctrl reset", 192'(q), 192'(CTRL_RESET));
      chk("error pin idle", 192'(link.error_out_n), 192'(1));
      chk("overtemp flag idle", 192'(ot_flag), 192'(0));
      wb(1'b0, 8'h08, 32'h0000_0000, q);
      chk("unmapped read", 192'(q), 192'(0));
      $display("reset test done");
   endtask : t_reset
   task automatic t_gray;
      ot_cmp <= 1'b1;
      det <= 16'hA5C3;
      load(gs1, 0);
      // gsclk is held still here, so no pwm cycle is cut by this latch
      run_frame(32'h0000_0000);
      chk("grayscale", gs_val, gs1);
      chk("trim held", 192'(trim_val), 192'(0));
      chk("error pin hot", 192'(link.error_out_n), 192'(0));
      $display("grayscale test done");
   endtask : t_gray
   task automatic t_status;
      logic [31:0]  q;
      logic [191:0] r;
      ot_cmp <= 1'b0;
      det <= 16'h0000;
      run_frame(32'h0000_0000);
      for (int k = 0; k < WORDS; k++) begin
         wb(1'b0, OFS_RX0 + 8'(4 * k), 32'h0000_0000, q);
         r = {r[159:0], q};
      end
      chk("status frame", r, {16'hA5C3, 1'b1, gs1[174:0]});
      chk("error pin cool", 192'(link.error_out_n), 192'(1));
      $display("status test done");
   endtask : t_status
   task automatic t_trim;
      load(192'(tr1), 3);
      run_frame(32'h0000_0002);
      chk("trim", 192'(trim_val), 192'(tr1));
      chk("grayscale held", gs_val, gs1);
      $display("trim test done");
   endtask : t_trim
   task automatic t_err;
      logic [31:0] q;
      det <= 16'h0100;
      settle(32'h0000_0004);
      chk("open led masked", 192'(link.error_out_n), 192'(1));
      chk("channels off", 192'(ch_out), 192'(0));
      settle(32'h0000_0000);
      chk("open led pulls", 192'(link.error_out_n), 192'(0));
      chk("open led flag", 192'(lod_flag), 192'(1));
      wb(1'b0, OFS_STATUS, 32'h0000_0000, q);
      chk("status error", 192'(q[STAT_ERR]), 192'(1));
      det <= 16'h0000;
      ot_cmp <= 1'b1;
      settle(32'h0000_0004);
      chk("hot not masked", 192'(link.error_out_n), 192'(0));
      chk("overtemp flag", 192'(ot_flag), 192'(1));
      ot_cmp <= 1'b0;
      $display("error test done");
   endtask : t_err
   task automatic t_pwm;
      settle(32'h0000_0000);
      chk("pwm at zero", 192'(ch_out), 192'(16'hFFFE));
      repeat (5) begin
         repeat (4) @(posedge core_clk);
         gsclk <= 1'b1;
         repeat (4) @(posedge core_clk);
         gsclk <= 1'b0;
      end
      repeat (8) @(posedge core_clk);
      chk("pwm at five", 192'(ch_out), 192'(16'hFFC0));
      $display("pwm test done");
   endtask : t_pwm
   // ------
   // run control
   // ------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      for (int i = 0; i < CHANNELS; i++) begin
         gs1[i * GS_W +: GS_W] = 12'(i);
         tr1[i * TRIM_W +: TRIM_W] = 6'(63 - i);
      end
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_gray();
      t_status();
      t_trim();
      t_err();
      t_pwm();
      finish_test();
   end
   // three frames of at most about 1600 cycles each plus register traffic
   initial begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      finish_test();
   end
endmodule : led_driver_serial_load_error_flags_test
`default_nettype wire
